// ---- core/one_pin_vsel_pkg.sv ----
// constants, types and states shared by the one-pin voltage-select receiver
package one_pin_vsel_pkg;

    // ==========================================================
    // clock and timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int STARTUP_TIME_NS = 170000;
    localparam int STARTUP_CYC =
        (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACK_HOLD_TIME_NS = 520000;
    localparam int ACK_HOLD_CYC = ACK_HOLD_TIME_NS / CLK_PERIOD_NS;
    localparam int TIMEOUT_TIME_NS = 520000;
    localparam int TIMEOUT_CYC = TIMEOUT_TIME_NS / CLK_PERIOD_NS;
    localparam int ACK_VALID_TIME_NS = 2000;
    localparam int ACK_VALID_CYC =
        (ACK_VALID_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
        ACK_VALID_TIME_NS / CLK_PERIOD_NS;

    // ==========================================================
    // frame layout
    localparam int CNT_W = 16;
    localparam int FRAME_BITS = 16;
    localparam logic [4:0] BYTE_END_IDX = 5'h07;
    localparam logic [4:0] FRAME_END_IDX = 5'h0f;
    localparam int ACK_REQ_POS = 7;
    localparam int REG_ADDR_HI_POS = 6;
    localparam int REG_ADDR_LO_POS = 5;
    localparam int CODE_MSB_POS = 4;
    localparam int CODE_W = 5;
    // arbitrary neutral device address
    localparam logic [7:0] DEV_ADDR_DEFAULT = 8'h5a;

    // ==========================================================
    // register select codes and reset values
    localparam logic [1:0] SEL_CONV1_LOW = 2'h0;
    localparam logic [1:0] SEL_CONV1_HIGH = 2'h1;
    localparam logic [1:0] SEL_CONV2 = 2'h2;
    localparam logic [1:0] SEL_UNUSED = 2'h3;
    localparam logic [4:0] CONV1_LOW_RESET = 5'h00;
    localparam logic [4:0] CONV1_HIGH_RESET = 5'h00;
    localparam logic [4:0] CONV2_RESET = 5'h00;

    typedef struct packed {
        logic [1:0] sel;
        logic [CODE_W-1:0] code;
    } reg_write_t;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_START,
        ST_IDLE,
        ST_LOW,
        ST_HIGH,
        ST_GAP,
        ST_VALID,
        ST_ACK
    } rx_state_t;

endpackage

// ---- core/one_pin_vsel_if.sv ----
// one-pin pulse-width serial receiver with mode select and voltage registers
`timescale 1ns/1ns
module one_pin_vsel_if
    import one_pin_vsel_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
    parameter int ACK_HOLD_CYCLES = ACK_HOLD_CYC,
    parameter int ACK_VALID_CYCLES = ACK_VALID_CYC,
    parameter int STARTUP_CYCLES = STARTUP_CYC,
    // arbitrary neutral value
    parameter logic [7:0] DEV_ADDR = DEV_ADDR_DEFAULT
)
(
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic serial_line_in,
    input wire logic conv1_voltage_select_pin_in,
    input wire logic converter_one_enable_in,
    input wire logic converter_two_enable_in,
    input wire logic write_stall_in,
    output logic serial_line_out,
    output logic serial_line_oe_out,
    output logic [CODE_W-1:0] conv1_code_out,
    output logic [CODE_W-1:0] conv2_code_out,
    output logic forced_pwm_out,
    output logic rx_busy_out
);

    // ==========================================================
    // input synchronisers
    logic line_meta_r, line_sync_r, line_prev_r;
    logic sel_meta_r, sel_sync_r;
    logic en_meta_r, en_sync_r;

    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            line_meta_r <= 1'b1;
            line_sync_r <= 1'b1;
            line_prev_r <= 1'b1;
            sel_meta_r <= 1'b0;
            sel_sync_r <= 1'b0;
            en_meta_r <= 1'b0;
            en_sync_r <= 1'b0;
        end
        else
        begin
            line_meta_r <= serial_line_in;
            line_sync_r <= line_meta_r;
            line_prev_r <= line_sync_r;
            sel_meta_r <= conv1_voltage_select_pin_in;
            sel_sync_r <= sel_meta_r;
            en_meta_r <= converter_one_enable_in | converter_two_enable_in;
            en_sync_r <= en_meta_r;
        end
    end

    logic fall, rise;
    assign fall = line_prev_r & ~line_sync_r;
    assign rise = ~line_prev_r & line_sync_r;

    // ==========================================================
    // receiver state machine
    rx_state_t state_r, state_nxt;
    logic [CNT_W-1:0] ph_low_r, ph_low_nxt, ph_high_r, ph_high_nxt;
    logic [CNT_W-1:0] line_low_r, line_low_nxt, tmr_r, tmr_nxt;
    logic [4:0] bit_cnt_r, bit_cnt_nxt;
    logic [FRAME_BITS-1:0] shift_r, shift_nxt;
    logic bad_r, bad_nxt, pend_r, pend_nxt, ack_req_r, ack_req_nxt;
    logic pwm_r, pwm_nxt, oe_r, oe_nxt;
    reg_write_t pend_word_r, pend_word_nxt;
    logic is_one, is_zero, timeout_hit, push;
    logic [CNT_W:0] low_dbl, high_dbl;
    logic [FRAME_BITS-1:0] frame;

    always_comb
    begin
        state_nxt = state_r;
        ph_low_nxt = ph_low_r;
        ph_high_nxt = ph_high_r;
        bit_cnt_nxt = bit_cnt_r;
        shift_nxt = shift_r;
        bad_nxt = bad_r;
        tmr_nxt = tmr_r;
        ack_req_nxt = ack_req_r;
        pend_word_nxt = pend_word_r;
        pend_nxt = pend_r & ~push;
        pwm_nxt = pwm_r;
        // saturating count of the current low stretch
        if (line_sync_r)
            line_low_nxt = '0;
        else if (line_low_r != {CNT_W{1'b1}})
            line_low_nxt = line_low_r + 1'b1;
        else
            line_low_nxt = line_low_r;
        timeout_hit = !line_sync_r &&
            (line_low_r >= CNT_W'(TIMEOUT_CYCLES - 1));
        low_dbl = {ph_low_r, 1'b0};
        high_dbl = {ph_high_r, 1'b0};
        is_one = {1'b0, ph_high_r} >= low_dbl;
        is_zero = {1'b0, ph_low_r} >= high_dbl;
        frame = {shift_r[FRAME_BITS-2:0], is_one};
        case (state_r)
            ST_OFF:
            begin
                tmr_nxt = '0;
                state_nxt = ST_START;
            end
            ST_START:
            begin
                tmr_nxt = tmr_r + 1'b1;
                if (tmr_r == CNT_W'(STARTUP_CYCLES - 1))
                    state_nxt = ST_IDLE;
            end
            ST_IDLE:
            begin
                if (fall)
                begin
                    state_nxt = ST_LOW;
                    bit_cnt_nxt = '0;
                    bad_nxt = 1'b0;
                    ph_low_nxt = '0;
                    ph_high_nxt = '0;
                end
            end
            ST_LOW:
            begin
                ph_low_nxt = ph_low_r + {{(CNT_W-1){1'b0}}, ~&ph_low_r};
                if (rise)
                    state_nxt = ST_HIGH;
                // lows past the timeout misframe and are dropped
                else if (timeout_hit)
                    state_nxt = ST_IDLE;
            end
            ST_HIGH:
            begin
                ph_high_nxt = ph_high_r + {{(CNT_W-1){1'b0}}, ~&ph_high_r};
                // period closes at next falling edge
                if (fall)
                begin
                    shift_nxt = frame;
                    bad_nxt = bad_r | ~(is_one | is_zero);
                    bit_cnt_nxt = bit_cnt_r + 1'b1;
                    ph_low_nxt = '0;
                    ph_high_nxt = '0;
                    state_nxt = ST_LOW;
                    if (bit_cnt_r == BYTE_END_IDX)
                        state_nxt = ST_GAP;
                    else if (bit_cnt_r == FRAME_END_IDX)
                    begin
                        state_nxt = ST_VALID;
                        tmr_nxt = '0;
                        // address byte, then request, select, code
                        // only good frames reach the registers
                        pend_nxt = !bad_nxt && frame[15:8] == DEV_ADDR &&
                            frame[REG_ADDR_HI_POS:REG_ADDR_LO_POS] !=
                            SEL_UNUSED;
                        pend_word_nxt.sel =
                            frame[REG_ADDR_HI_POS:REG_ADDR_LO_POS];
                        pend_word_nxt.code = frame[CODE_MSB_POS:0];
                        ack_req_nxt = pend_nxt & frame[ACK_REQ_POS];
                    end
                end
            end
            ST_GAP:
            begin
                // end-of-stream low and start high carry no bit
                if (fall)
                    state_nxt = ST_LOW;
                else if (timeout_hit)
                    state_nxt = ST_IDLE;
            end
            ST_VALID:
            begin
                // validity delay from last falling edge
                tmr_nxt = tmr_r + 1'b1;
                if (tmr_r == CNT_W'(ACK_VALID_CYCLES - 1))
                begin
                    tmr_nxt = '0;
                    // no pull-down on a failed frame
                    if (ack_req_r && !pend_nxt)
                        state_nxt = ST_ACK;
                    else
                        state_nxt = ST_IDLE;
                end
            end
            ST_ACK:
            begin
                tmr_nxt = tmr_r + 1'b1;
                if (tmr_r == CNT_W'(ACK_HOLD_CYCLES - 1))
                    state_nxt = ST_IDLE;
            end
            default:
                state_nxt = ST_OFF;
        endcase
        // receiver runs only while a converter is enabled
        if (!en_sync_r)
            state_nxt = ST_OFF;
        // forced mode on high line and through reception
        if (line_sync_r || state_r == ST_LOW || state_r == ST_HIGH ||
            state_r == ST_GAP)
            pwm_nxt = 1'b1;
        else if (timeout_hit)
            pwm_nxt = 1'b0;
        oe_nxt = (state_nxt == ST_ACK);
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state_r <= ST_OFF;
            ph_low_r <= '0;
            ph_high_r <= '0;
            line_low_r <= '0;
            tmr_r <= '0;
            bit_cnt_r <= '0;
            shift_r <= '0;
            bad_r <= 1'b0;
            pend_r <= 1'b0;
            pend_word_r <= '0;
            ack_req_r <= 1'b0;
            pwm_r <= 1'b1;
            oe_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            ph_low_r <= ph_low_nxt;
            ph_high_r <= ph_high_nxt;
            line_low_r <= line_low_nxt;
            tmr_r <= tmr_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            shift_r <= shift_nxt;
            bad_r <= bad_nxt;
            pend_r <= pend_nxt;
            pend_word_r <= pend_word_nxt;
            ack_req_r <= ack_req_nxt;
            pwm_r <= pwm_nxt;
            oe_r <= oe_nxt;
        end
    end

    // ==========================================================
    // two-entry write buffer; a full buffer withholds the acknowledge
    reg_write_t buf_r [2];
    reg_write_t buf_nxt [2];
    logic wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
    logic [1:0] fill_r, fill_nxt;
    logic in_ready, out_valid, pop;

    assign in_ready = fill_r != 2'h2;
    assign out_valid = fill_r != 2'h0;
    assign push = pend_r & in_ready;
    assign pop = out_valid & ~write_stall_in;

    always_comb
    begin
        buf_nxt = buf_r;
        wr_ptr_nxt = wr_ptr_r ^ push;
        rd_ptr_nxt = rd_ptr_r ^ pop;
        fill_nxt = fill_r + {1'b0, push} - {1'b0, pop};
        if (push)
            buf_nxt[wr_ptr_r] = pend_word_r;
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            buf_r[0] <= '0;
            buf_r[1] <= '0;
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            fill_r <= 2'h0;
        end
        else
        begin
            buf_r <= buf_nxt;
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            fill_r <= fill_nxt;
        end
    end

    // ==========================================================
    // voltage registers and outputs
    logic [CODE_W-1:0] low_r, low_nxt, high_r, high_nxt, c2_r, c2_nxt;
    logic [CODE_W-1:0] c1_out_r, c1_out_nxt;
    reg_write_t head;

    assign head = buf_r[rd_ptr_r];

    always_comb
    begin
        low_nxt = low_r;
        high_nxt = high_r;
        c2_nxt = c2_r;
        // address decode of the three registers
        if (pop && head.sel == SEL_CONV1_LOW)
            low_nxt = head.code;
        else if (pop && head.sel == SEL_CONV1_HIGH)
            high_nxt = head.code;
        else if (pop && head.sel == SEL_CONV2)
            c2_nxt = head.code;
        // select pin picks converter 1 register
        c1_out_nxt = sel_sync_r ? high_r : low_r;
    end

    // only the reset clears these, never an enable
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            low_r <= CONV1_LOW_RESET;
            high_r <= CONV1_HIGH_RESET;
            c2_r <= CONV2_RESET;
            c1_out_r <= CONV1_LOW_RESET;
        end
        else
        begin
            low_r <= low_nxt;
            high_r <= high_nxt;
            c2_r <= c2_nxt;
            c1_out_r <= c1_out_nxt;
        end
    end

    assign conv1_code_out = c1_out_r;
    assign conv2_code_out = c2_r;
    assign forced_pwm_out = pwm_r;
    assign serial_line_oe_out = oe_r;
    // open drain: only ever pulls low
    assign serial_line_out = 1'b0;
    assign rx_busy_out = pend_r;

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!arst_n_in);

    logic [CNT_W-1:0] oe_len_r;
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            oe_len_r <= '0;
        else
            oe_len_r <= oe_r ? oe_len_r + 1'b1 : '0;
    end

    a_ack_hold_bound: assert property (
        oe_len_r <= CNT_W'(ACK_HOLD_CYCLES))
        else $error("acknowledge pull-down held too long");
    a_ack_needs_request: assert property (
        $rose(oe_r) |-> $past(ack_req_r) && $past(state_r) == ST_VALID)
        else $error("acknowledge without valid request");
    a_ack_after_delay: assert property (
        $rose(oe_r) |-> $past(tmr_r) == CNT_W'(ACK_VALID_CYCLES - 1))
        else $error("acknowledge before validity delay");
    a_off_when_disabled: assert property (
        !en_sync_r |=> state_r == ST_OFF && !oe_r)
        else $error("receiver active while converters disabled");
    a_no_decode_start: assert property (
        state_r == ST_START && tmr_r < CNT_W'(STARTUP_CYCLES - 1)
        |=> state_r != ST_LOW)
        else $error("decoding during startup");
    a_high_forces_pwm: assert property (
        line_sync_r |=> pwm_r)
        else $error("high line did not force fixed frequency");
    a_timeout_saves: assert property (
        timeout_hit && state_r == ST_IDLE |=> !pwm_r)
        else $error("timeout did not enter power save");
    a_bits_on_fall: assert property (
        bit_cnt_r != $past(bit_cnt_r) && bit_cnt_r != 5'h00
        |-> $past(fall) && $past(state_r) == ST_HIGH)
        else $error("bit completed without falling edge");
    a_no_write_bad: assert property (
        $rose(pend_r) |-> !bad_r && shift_r[15:8] == DEV_ADDR)
        else $error("failed frame queued for write");
    a_unused_never: assert property (
        pop |-> head.sel != SEL_UNUSED)
        else $error("unused register address written");
    a_conv1_select: assert property (
        sel_sync_r |=> c1_out_r == $past(high_r))
        else $error("converter 1 ignores select pin");

    c_ack_frame: cover property ($rose(oe_r));
    c_write_frame: cover property (push && !ack_req_r);
    c_power_save: cover property ($fell(pwm_r));
    c_buffer_full: cover property (fill_r == 2'h2 && pend_r);

endmodule

// ---- sim/host_line_model.sv ----
// host model: open-drain driver of the shared one-pin serial line
`timescale 1ns/1ns
module host_line_model
(
    input wire logic clk_sys_in,
    input wire logic line_in,
    output logic drive_low_out,
    output logic in_frame_out
);
    initial drive_low_out = 1'b0;
    initial in_frame_out = 1'b0;

    // ==========================================================
    // bit and byte timing
    // fall, low, high, next fall closes
    task automatic send_bit(input int low_cyc, input int high_cyc);
    begin
        drive_low_out <= 1'b1;
        repeat (low_cyc) @(posedge clk_sys_in);
        drive_low_out <= 1'b0;
        repeat (high_cyc) @(posedge clk_sys_in);
    end
    endtask

    // msb first; bad_idx gives a bit with no valid ratio
    task automatic send_byte(input logic [7:0] val, input int bad_idx);
        int i;
    begin
        for (i = 7; i >= 0; i--)
        begin
            if (i == bad_idx)
                send_bit(8, 8);
            else if (val[i])
                send_bit(4, 12);
            else
                send_bit(12, 4);
        end
    end
    endtask

    // ==========================================================
    // whole transfer
    task automatic send_frame(input logic [7:0] addr, input logic [7:0] dat,
        input int bad_idx, output logic acked);
        int i;
    begin
        // start high first, no low window before it
        drive_low_out <= 1'b0;
        repeat (30) @(posedge clk_sys_in);
        in_frame_out <= 1'b1;
        send_byte(addr, -1);
        send_bit(20, 20);
        send_byte(dat, bad_idx);
        // hold low through the validity delay, then sample
        drive_low_out <= 1'b1;
        repeat (12) @(posedge clk_sys_in);
        drive_low_out <= 1'b0;
        in_frame_out <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        acked = !line_in;
        // keep off the line until the pull-down ends
        for (i = 0; i < 400 && line_in !== 1'b1; i++)
            @(posedge clk_sys_in);
        repeat (4) @(posedge clk_sys_in);
    end
    endtask
endmodule

// ---- sim/tb.sv ----
// testbench for the one-pin voltage-select receiver
`timescale 1ns/1ns
module tb;
    import one_pin_vsel_pkg::*;
    localparam int T_OUT = 200;
    localparam int HOLD = 100;
    localparam int START = 20;
    localparam logic [7:0] ADR = DEV_ADDR_DEFAULT;
    logic clk_sys_in, arst_n_in, sel_pin, en1, en2, stall;
    logic host_low, in_frame, line_oe, line_dout, line, pwm, busy;
    logic [CODE_W-1:0] c1, c2;
    int err_count, check_count, cyc, oe_run, oe_len, pwm_drop, k;
    logic [1:0] sels [3] = '{SEL_CONV1_LOW, SEL_CONV1_HIGH, SEL_CONV2};
    logic [4:0] codes [3] = '{5'h15, 5'h0a, 5'h1f};

    // pull-up on the wire; either party may pull it low
    assign line = (host_low || (line_oe && !line_dout)) ? 1'b0 : 1'b1;

    one_pin_vsel_if #(.TIMEOUT_CYCLES(T_OUT), .ACK_HOLD_CYCLES(HOLD),
        .ACK_VALID_CYCLES(4), .STARTUP_CYCLES(START)) u_dut
    (
        .clk_sys_in(clk_sys_in),
        .arst_n_in(arst_n_in),
        .serial_line_in(line),
        .conv1_voltage_select_pin_in(sel_pin),
        .converter_one_enable_in(en1),
        .converter_two_enable_in(en2),
        .write_stall_in(stall),
        .serial_line_out(line_dout),
        .serial_line_oe_out(line_oe),
        .conv1_code_out(c1),
        .conv2_code_out(c2),
        .forced_pwm_out(pwm),
        .rx_busy_out(busy)
    );

    host_line_model u_host
    (
        .clk_sys_in(clk_sys_in),
        .line_in(line),
        .drive_low_out(host_low),
        .in_frame_out(in_frame)
    );

    initial
    begin
        clk_sys_in = 1'b0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end

    // ==========================================================
    // reporting
    task automatic check(input string what, input logic [7:0] exp,
        input logic [7:0] got);
    begin
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    end
    endtask

    task automatic test_done();
    begin
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
    endtask

    task automatic xfer(input logic [7:0] addr, input logic [7:0] dat,
        input int bad, input logic exp_ack);
        logic got;
    begin
        u_host.send_frame(addr, dat, bad, got);
        check("ack", {7'h00, exp_ack}, {7'h00, got});
        repeat (10) @(posedge clk_sys_in);
    end
    endtask

    // ==========================================================
    // monitors: pull-down length, early pull-down, mode, hang
    always @(posedge clk_sys_in)
    begin
        cyc++;
        // oe rising while the host still holds low means it waited
        if (line_oe === 1'b1 && oe_run == 0 && host_low !== 1'b1)
            check("oe early", 8'h00, 8'h01);
        if (line_oe === 1'b1)
            oe_run++;
        else if (oe_run != 0)
        begin
            oe_len = oe_run;
            oe_run = 0;
        end
        if (in_frame && en1 === 1'b1 && pwm !== 1'b1)
            pwm_drop++;
        if (cyc == 20000)
        begin
            err_count++;
            $display("timeout at cycle %0d", cyc);
            test_done();
        end
    end

    // ==========================================================
    // main sequence
    initial
    begin
        arst_n_in = 1'b0;
        sel_pin = 1'b0;
        en1 = 1'b0;
        en2 = 1'b0;
        stall = 1'b0;
        repeat (6) @(posedge clk_sys_in);
        check("reset oe", 8'h00, {7'h00, line_oe});
        check("reset pwm", 8'h01, {7'h00, pwm});
        check("reset code1", 8'h00, {3'h0, c1});
        check("reset code2", 8'h00, {3'h0, c2});
        arst_n_in <= 1'b1;
        repeat (10) @(posedge clk_sys_in);
        xfer(ADR, 8'hbf, -1, 1'b0);
        check("disabled code2", 8'h00, {3'h0, c2});
        $display("test disabled done");

        en1 <= 1'b1;
        repeat (START + 10) @(posedge clk_sys_in);
        for (k = 0; k < 3; k++)
        begin
            xfer(ADR, {1'b1, sels[k], codes[k]}, -1, 1'b1);
            check("ack hold", HOLD, oe_len[7:0]);
        end
        sel_pin <= 1'b1;
        repeat (6) @(posedge clk_sys_in);
        check("code1 high", {3'h0, codes[1]}, {3'h0, c1});
        sel_pin <= 1'b0;
        repeat (6) @(posedge clk_sys_in);
        check("code1 low", {3'h0, codes[0]}, {3'h0, c1});
        check("code2", {3'h0, codes[2]}, {3'h0, c2});
        $display("test writes done");

        xfer(ADR ^ 8'h01, 8'ha1, -1, 1'b0);
        xfer(ADR, 8'he2, -1, 1'b0);
        xfer(ADR, 8'h83, 2, 1'b0);
        check("kept code1", {3'h0, codes[0]}, {3'h0, c1});
        check("kept code2", {3'h0, codes[2]}, {3'h0, c2});
        xfer(ADR, 8'h40, -1, 1'b0);
        check("no-ack write", 8'h00, {3'h0, c2});
        $display("test rejects done");

        stall <= 1'b1;
        xfer(ADR, 8'hc3, -1, 1'b1);
        xfer(ADR, 8'hc4, -1, 1'b1);
        xfer(ADR, 8'hc5, -1, 1'b0);
        check("busy", 8'h01, {7'h00, busy});
        check("stalled code2", 8'h00, {3'h0, c2});
        stall <= 1'b0;
        repeat (12) @(posedge clk_sys_in);
        check("drained code2", 8'h05, {3'h0, c2});
        check("busy clear", 8'h00, {7'h00, busy});
        $display("test buffer done");

        u_host.send_bit(T_OUT + 20, 0);
        check("power save", 8'h00, {7'h00, pwm});
        repeat (6) @(posedge clk_sys_in);
        check("forced pwm", 8'h01, {7'h00, pwm});
        check("pwm in frame", 8'h00, pwm_drop[7:0]);
        $display("test mode done");

        en1 <= 1'b0;
        repeat (20) @(posedge clk_sys_in);
        check("off code1", {3'h0, codes[0]}, {3'h0, c1});
        check("off code2", 8'h05, {3'h0, c2});
        $display("test persist done");

        // second enable alone must wake the receiver
        en2 <= 1'b1;
        repeat (START + 10) @(posedge clk_sys_in);
        xfer(ADR, 8'hc6, -1, 1'b1);
        check("en2 code2", 8'h06, {3'h0, c2});
        check("en2 code1", {3'h0, codes[0]}, {3'h0, c1});
        $display("test second enable done");
        test_done();
    end
endmodule
